// *** hdl/urs_regmap.v ***
// UART channel register select map with receive and transmit byte FIFOs.
`timescale 1ns/10ps
`include "urs_defines.vh"

module urs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire clock_i,
	input wire rst_n_i,
	input wire flush_i,
	// Filling side.
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	// Draining side.
	output wire [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i,
	// Fill level.
	output wire [AW:0] count_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign in_ready_o = (count != DEPTH[AW:0]) & ~flush_i;
	assign out_valid_o = (count != {(AW+1){1'b0}}) & ~flush_i;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rd_ptr];
	assign count_o = count;

	always @(posedge clock_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else if (flush_i)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				count <= count + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				count <= count - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // urs_fifo

// Functional notes
// - Host selects registers with three address lines while chip select is low.
// - Address 0, divisor enable clear: read receive byte, write transmit byte.
// - Divisor enable set, not 0xBF: addresses 0 and 1 reach divisor bytes.
// - Fractional divisor at address 2 needs divisor and enhanced enable; low nibble.
// - Zero divisor shows read-only revision and part codes at addresses 0, 1.
// - Address 1, divisor enable clear: interrupt enable register with six bits.
// - Address 2 read shows interrupt status, FIFO enabled bits and source code.
// - Address 2 write loads FIFO control: enable, flushes, DMA, triggers.
// - Line control at address 3 always reachable with its field layout.
// - Modem control at address 4 with handshake, loopback and enhanced bits.
// - Read-only line status at address 5 reports receive and transmit state.
// - Read-only modem status at address 6 with change flag and input states.
// - Address 7 with feature bit 6 clear is a scratch byte.
// - Address 7 read with feature bit 6 set returns FIFO fill level.
// - Address 7 write with feature bit 6 set loads enhanced mode select.
// - Line control 0xBF: address 0 writes trigger level, reads level count.
// - Line control 0xBF: addresses 1 and 2 reach feature and enhanced registers.
// - Line control 0xBF: addresses 4 to 7 hold the four flow characters.
// - Enhanced bits act and read only while enhanced enable is set.
module urs_regmap (
	// Clock and reset.
	input wire clock_i,
	input wire rst_n_i,
	// Host parallel bus pins.
	input wire cs_n_i,
	input wire [2:0] addr_i,
	input wire rd_n_i,
	input wire wr_n_i,
	input wire [7:0] data_i,
	output reg [7:0] data_o,
	output wire data_oe_o,
	// Receive byte stream from the serial receiver.
	input wire [7:0] rx_data_i,
	input wire rx_valid_i,
	output wire rx_ready_o,
	// Transmit byte stream to the serial transmitter.
	output wire [7:0] tx_data_o,
	output wire tx_valid_o,
	input wire tx_ready_i,
	input wire tx_idle_i,
	// Status from the serial core.
	input wire [3:0] line_error_i,
	input wire rx_fifo_error_i,
	input wire [5:0] int_source_i,
	input wire [3:0] modem_in_i,
	// Configuration toward the serial core.
	output reg [7:0] line_control_o,
	output reg [15:0] divisor_o,
	output reg [3:0] divisor_fraction_o,
	output reg [7:0] interrupt_enable_o,
	output reg [7:0] fifo_control_o,
	output reg [7:0] modem_control_o,
	output reg spare_output_one_o,
	output reg [7:0] feature_control_o,
	output reg [7:0] enhanced_function_o,
	output reg [7:0] enhanced_mode_select_o,
	output reg [7:0] fifo_trigger_level_o,
	output reg [7:0] flow_resume_char_1_o,
	output reg [7:0] flow_resume_char_2_o,
	output reg [7:0] flow_stop_char_1_o,
	output reg [7:0] flow_stop_char_2_o
);
	reg [1:0] rst_pipe;
	wire rst_sync_n;
	reg [13:0] pin_meta;
	reg [13:0] pin_sync;
	reg rd_prev;
	reg wr_prev;
	reg rd_active;
	reg [7:0] divisor_low;
	reg [7:0] divisor_high;
	reg [3:0] divisor_fraction;
	reg [7:0] interrupt_enable;
	reg [7:0] fifo_control;
	reg [7:0] line_control;
	reg [7:0] modem_control;
	reg [7:0] scratch_byte;
	reg [7:0] feature_control;
	reg [7:0] enhanced_function;
	reg [7:0] enhanced_mode_select;
	reg [7:0] fifo_trigger_level;
	reg [7:0] flow_resume_char_1;
	reg [7:0] flow_resume_char_2;
	reg [7:0] flow_stop_char_1;
	reg [7:0] flow_stop_char_2;
	reg cts_prev;
	reg delta_cts;
	reg rx_flush;
	reg tx_flush;
	reg [7:0] next_read;
	wire cs_s;
	wire rd_s;
	wire wr_s;
	wire [2:0] addr_s;
	wire [7:0] wdata_s;
	wire rd_start;
	wire wr_done;
	wire bf_mode;
	wire div_en;
	wire enh_en;
	wire div_zero;
	wire [7:0] enh_gate;
	wire [7:0] modem_gate;
	wire [5:0] int_source_masked;
	wire [7:0] rx_fifo_data;
	wire rx_fifo_valid;
	wire rx_pop;
	wire tx_push;
	wire tx_fifo_ready;
	wire [4:0] rx_count;
	wire [4:0] tx_count;
	wire [7:0] rx_level;
	wire [7:0] tx_level;
	wire [7:0] line_status;
	wire [7:0] modem_status;
	wire [7:0] interrupt_status;

	// Reset is asserted at once and released through two flip-flops.
	always @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_n = rst_pipe[1];

	// Every host pin passes two flip-flops before the decode looks at it.
	always @(posedge clock_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pin_meta <= 14'h0007;
			pin_sync <= 14'h0007;
		end
		else
		begin
			pin_meta <= {data_i, addr_i, wr_n_i, rd_n_i, cs_n_i};
			pin_sync <= pin_meta;
		end
	end
	assign cs_s = ~pin_sync[0];
	assign rd_s = ~pin_sync[1];
	assign wr_s = ~pin_sync[2];
	assign addr_s = pin_sync[5:3];
	assign wdata_s = pin_sync[13:6];

	// A read is taken as the strobe opens, a write as it closes with data settled.
	assign rd_start = rd_s & ~rd_prev & cs_s;
	assign wr_done = ~wr_s & wr_prev & cs_s;
	assign data_oe_o = rd_active & rd_s;

	assign bf_mode = (line_control == `URS_LINE_CTL_ENHANCED);
	assign div_en = line_control[`URS_LINE_CTL_DIV_EN];
	assign enh_en = enhanced_function[`URS_ENH_FUNC_ENH_EN];
	assign div_zero = (divisor_low == `URS_RST_DIV) & (divisor_high == `URS_RST_DIV);
	assign enh_gate = enh_en ? 8'hFF : ~`URS_ENH_MASK;
	assign modem_gate = enh_en ? 8'hFF : ~`URS_MODEM_CTL_ENH_MASK;

	// Receive and transmit paths each hold sixteen bytes.
	assign rx_pop = rd_start & (addr_s == `URS_ADDR_HOLD) & ~bf_mode & ~div_en;
	assign tx_push = wr_done & (addr_s == `URS_ADDR_HOLD) & ~bf_mode & ~div_en;

	urs_fifo #(
		.WIDTH(`URS_FIFO_WIDTH),
		.DEPTH(`URS_FIFO_DEPTH),
		.AW(`URS_FIFO_AW)
	) u_rx_fifo (
		.clock_i(clock_i),
		.rst_n_i(rst_sync_n),
		.flush_i(rx_flush),
		.in_data_i(rx_data_i),
		.in_valid_i(rx_valid_i),
		.in_ready_o(rx_ready_o),
		.out_data_o(rx_fifo_data),
		.out_valid_o(rx_fifo_valid),
		.out_ready_i(rx_pop),
		.count_o(rx_count)
	);

	urs_fifo #(
		.WIDTH(`URS_FIFO_WIDTH),
		.DEPTH(`URS_FIFO_DEPTH),
		.AW(`URS_FIFO_AW)
	) u_tx_fifo (
		.clock_i(clock_i),
		.rst_n_i(rst_sync_n),
		.flush_i(tx_flush),
		.in_data_i(wdata_s),
		.in_valid_i(tx_push),
		.in_ready_o(tx_fifo_ready),
		.out_data_o(tx_data_o),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i),
		.count_o(tx_count)
	);

	assign rx_level = {3'h0, rx_count};
	assign tx_level = {3'h0, tx_count};
	assign line_status = {rx_fifo_error_i, ~tx_valid_o & tx_idle_i, tx_fifo_ready, line_error_i,
		rx_fifo_valid};
	assign modem_status = {modem_in_i, 3'h0, delta_cts};
	assign int_source_masked = int_source_i & (enh_en ? 6'h3F : ~`URS_INT_STAT_ENH_MASK);
	assign interrupt_status = {{2{fifo_control[`URS_FIFO_CTL_EN]}}, int_source_masked};

	// Read multiplexer, steered by line control, divisor and feature bits.
	always @*
	begin
		next_read = `URS_RST_BYTE;
		case (addr_s)
			`URS_ADDR_HOLD:
			begin
				if (bf_mode)
					next_read = feature_control[`URS_FEAT_LEVEL_TX] ? tx_level : rx_level;
				else if (div_en)
					next_read = div_zero ? `URS_REV_CODE : divisor_low;
				else
					next_read = rx_fifo_data;
			end
			`URS_ADDR_INT_EN:
			begin
				if (bf_mode)
					next_read = feature_control;
				else if (div_en)
					next_read = div_zero ? `URS_PART_ID : divisor_high;
				else
					next_read = interrupt_enable & enh_gate;
			end
			`URS_ADDR_INT_STAT:
			begin
				if (bf_mode)
					next_read = enhanced_function;
				else if (div_en & enh_en)
					next_read = {4'h0, divisor_fraction};
				else
					next_read = interrupt_status;
			end
			`URS_ADDR_LINE_CTL:
				next_read = line_control;
			`URS_ADDR_MODEM_CTL:
				next_read = bf_mode ? flow_resume_char_1 : modem_control & modem_gate;
			`URS_ADDR_LINE_STAT:
				next_read = bf_mode ? flow_resume_char_2 : line_status;
			`URS_ADDR_MODEM_STAT:
				next_read = bf_mode ? flow_stop_char_1 : modem_status;
			`URS_ADDR_SCRATCH:
			begin
				if (bf_mode)
					next_read = flow_stop_char_2;
				else if (feature_control[`URS_FEAT_SCRATCH_SWAP])
					next_read = enhanced_mode_select[`URS_MODE_SEL_CNT_TX] ? tx_level : rx_level;
				else
					next_read = scratch_byte;
			end
			default:
				next_read = `URS_RST_BYTE;
		endcase
	end

	// Strobe tracking, read data capture and modem change flag.
	always @(posedge clock_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			rd_prev <= 1'b0;
			wr_prev <= 1'b0;
			rd_active <= 1'b0;
			data_o <= `URS_RST_BYTE;
			cts_prev <= 1'b0;
			delta_cts <= 1'b0;
		end
		else
		begin
			rd_prev <= rd_s;
			wr_prev <= wr_s;
			if (rd_start)
			begin
				rd_active <= 1'b1;
				data_o <= next_read;
			end
			else if (~rd_s)
				rd_active <= 1'b0;
			cts_prev <= modem_in_i[0];
			// A fresh change wins over the clear that a status read makes.
			if (modem_in_i[0] != cts_prev)
				delta_cts <= 1'b1;
			else if (rd_start & (addr_s == `URS_ADDR_MODEM_STAT) & ~bf_mode)
				delta_cts <= 1'b0;
		end
	end

	// Register writes, decoded by address and the current select state.
	always @(posedge clock_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			divisor_low <= `URS_RST_DIV;
			divisor_high <= `URS_RST_DIV;
			divisor_fraction <= 4'h0;
			interrupt_enable <= `URS_RST_BYTE;
			fifo_control <= `URS_RST_BYTE;
			line_control <= `URS_RST_LINE_CTL;
			modem_control <= `URS_RST_MODEM_CTL;
			scratch_byte <= `URS_RST_BYTE;
			feature_control <= `URS_RST_BYTE;
			enhanced_function <= `URS_RST_BYTE;
			enhanced_mode_select <= `URS_RST_BYTE;
			fifo_trigger_level <= `URS_RST_BYTE;
			flow_resume_char_1 <= `URS_RST_BYTE;
			flow_resume_char_2 <= `URS_RST_BYTE;
			flow_stop_char_1 <= `URS_RST_BYTE;
			flow_stop_char_2 <= `URS_RST_BYTE;
			rx_flush <= 1'b0;
			tx_flush <= 1'b0;
		end
		else
		begin
			rx_flush <= 1'b0;
			tx_flush <= 1'b0;
			if (wr_done)
			begin
				case (addr_s)
					`URS_ADDR_HOLD:
					begin
						if (bf_mode)
							fifo_trigger_level <= wdata_s;
						else if (div_en)
							divisor_low <= wdata_s;
					end
					`URS_ADDR_INT_EN:
					begin
						if (bf_mode)
							feature_control <= wdata_s;
						else if (div_en)
							divisor_high <= wdata_s;
						else
							interrupt_enable <= wdata_s & 8'h3F;
					end
					`URS_ADDR_INT_STAT:
					begin
						if (bf_mode)
							enhanced_function <= wdata_s;
						else if (div_en & enh_en)
							divisor_fraction <= wdata_s[3:0];
						else
						begin
							// Flush bits act once and are not kept.
							fifo_control <= wdata_s & 8'hF9;
							rx_flush <= wdata_s[`URS_FIFO_CTL_RX_FLUSH];
							tx_flush <= wdata_s[`URS_FIFO_CTL_TX_FLUSH];
						end
					end
					`URS_ADDR_LINE_CTL:
						line_control <= wdata_s;
					`URS_ADDR_MODEM_CTL:
					begin
						if (bf_mode)
							flow_resume_char_1 <= wdata_s;
						else
							modem_control <= wdata_s;
					end
					`URS_ADDR_LINE_STAT:
					begin
						if (bf_mode)
							flow_resume_char_2 <= wdata_s;
					end
					`URS_ADDR_MODEM_STAT:
					begin
						if (bf_mode)
							flow_stop_char_1 <= wdata_s;
					end
					`URS_ADDR_SCRATCH:
					begin
						if (bf_mode)
							flow_stop_char_2 <= wdata_s;
						else if (feature_control[`URS_FEAT_SCRATCH_SWAP])
							enhanced_mode_select <= wdata_s;
						else
							scratch_byte <= wdata_s;
					end
					default:
						scratch_byte <= scratch_byte;
				endcase
			end
		end
	end

	// Configuration outputs, with enhanced fields held at zero while disabled.
	always @(posedge clock_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			line_control_o <= `URS_RST_LINE_CTL;
			divisor_o <= {`URS_RST_DIV, `URS_RST_DIV};
			divisor_fraction_o <= 4'h0;
			interrupt_enable_o <= `URS_RST_BYTE;
			fifo_control_o <= `URS_RST_BYTE;
			modem_control_o <= `URS_RST_MODEM_CTL;
			spare_output_one_o <= 1'b0;
			feature_control_o <= `URS_RST_BYTE;
			enhanced_function_o <= `URS_RST_BYTE;
			enhanced_mode_select_o <= `URS_RST_BYTE;
			fifo_trigger_level_o <= `URS_RST_BYTE;
			flow_resume_char_1_o <= `URS_RST_BYTE;
			flow_resume_char_2_o <= `URS_RST_BYTE;
			flow_stop_char_1_o <= `URS_RST_BYTE;
			flow_stop_char_2_o <= `URS_RST_BYTE;
		end
		else
		begin
			line_control_o <= line_control;
			divisor_o <= {divisor_high, divisor_low};
			divisor_fraction_o <= divisor_fraction & (enh_en ? 4'hF : 4'h0);
			interrupt_enable_o <= interrupt_enable & enh_gate;
			fifo_control_o <= fifo_control & (enh_en ? 8'hFF : ~`URS_FIFO_CTL_ENH_MASK);
			modem_control_o <= modem_control & modem_gate & 8'hFB;
			spare_output_one_o <= modem_control[2];
			feature_control_o <= feature_control;
			enhanced_function_o <= enhanced_function;
			enhanced_mode_select_o <= enhanced_mode_select;
			fifo_trigger_level_o <= fifo_trigger_level;
			flow_resume_char_1_o <= flow_resume_char_1;
			flow_resume_char_2_o <= flow_resume_char_2;
			flow_stop_char_1_o <= flow_stop_char_1;
			flow_stop_char_2_o <= flow_stop_char_2;
		end
	end
endmodule // urs_regmap

// *** hdl/urs_defines.vh ***
// Register select constants, field positions and reset values for the UART register map.
`ifndef URS_DEFINES_VH
`define URS_DEFINES_VH
`define URS_ADDR_HOLD 3'h0
`define URS_ADDR_INT_EN 3'h1
`define URS_ADDR_INT_STAT 3'h2
`define URS_ADDR_LINE_CTL 3'h3
`define URS_ADDR_MODEM_CTL 3'h4
`define URS_ADDR_LINE_STAT 3'h5
`define URS_ADDR_MODEM_STAT 3'h6
`define URS_ADDR_SCRATCH 3'h7
`define URS_LINE_CTL_ENHANCED 8'hBF
`define URS_LINE_CTL_DIV_EN 7
`define URS_ENH_FUNC_ENH_EN 4
`define URS_FEAT_SCRATCH_SWAP 6
`define URS_FEAT_LEVEL_TX 7
`define URS_FIFO_CTL_EN 0
`define URS_FIFO_CTL_RX_FLUSH 1
`define URS_FIFO_CTL_TX_FLUSH 2
`define URS_MODE_SEL_CNT_TX 0
`define URS_ENH_MASK 8'hF0
`define URS_MODEM_CTL_ENH_MASK 8'hE0
`define URS_INT_STAT_ENH_MASK 6'h30
`define URS_FIFO_CTL_ENH_MASK 8'h30
`define URS_FRACTION_MASK 8'h0F
`define URS_RST_BYTE 8'h00
`define URS_RST_LINE_CTL 8'h00
`define URS_RST_MODEM_CTL 8'h00
`define URS_RST_DIV 8'h00
`define URS_FIFO_WIDTH 8
`define URS_FIFO_DEPTH 16
`define URS_FIFO_AW 4
// The revision and part codes below are arbitrary values.
`define URS_REV_CODE 8'h01
`define URS_PART_ID 8'h5C
`endif

// *** bench/urs_host_model.sv ***
// Host processor model that drives the parallel register bus.
`timescale 1ns/10ps
module urs_host_model (
	// Clock.
	input wire clock_i,
	// Bus toward the device.
	output logic cs_n_o,
	output logic [2:0] addr_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [7:0] data_o,
	input wire [7:0] rdata_i,
	input wire rdata_oe_i
);
	initial
	begin
		cs_n_o = 1'b1;
		addr_o = 3'h0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		data_o = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// Select, address and data outlast each strobe by four clocks.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		cs_n_o = 1'b0;
		addr_o = a;
		data_o = d;
		wr_n_o = 1'b0;
		step(5);
		wr_n_o = 1'b1;
		step(4);
		cs_n_o = 1'b1;
		// A released bus must not keep showing the last byte.
		data_o = ~d;
		step(4);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		int n;
		cs_n_o = 1'b0;
		addr_o = a;
		rd_n_o = 1'b0;
		n = 0;
		step(1);
		while (rdata_oe_i !== 1'b1 && n < 12)
		begin
			step(1);
			n++;
		end
		d = rdata_i;
		step(2);
		rd_n_o = 1'b1;
		step(4);
		cs_n_o = 1'b1;
		step(4);
	endtask
endmodule // urs_host_model

// *** bench/urs_regmap_props.sv ***
// Checker of the register map's port behaviour.
`timescale 1ns/10ps
module urs_regmap_props (
	// Clock and reset.
	input wire clock_i,
	input wire rst_n_i,
	// Host bus.
	input wire cs_n_i,
	input wire rd_n_i,
	input wire wr_n_i,
	input wire [7:0] data_o,
	input wire data_oe_o,
	// Configuration and stream.
	input wire tx_valid_o,
	input wire [7:0] line_control_o,
	input wire [15:0] divisor_o,
	input wire [7:0] interrupt_enable_o,
	input wire [7:0] modem_control_o,
	input wire [7:0] enhanced_function_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_rd_held;
		data_oe_o && !rd_n_i;
	endsequence
	sequence s_rd_gone;
		rd_n_i [*4];
	endsequence
	AST_OE_CAUSE: assert property ($rose(data_oe_o) |-> !$past(rd_n_i, 2) && !$past(cs_n_i, 2))
		else $error("read data driven without a read strobe");
	AST_OE_HOLD: assert property (s_rd_held |=> data_oe_o)
		else $error("read data dropped while strobe low");
	AST_OE_DROP: assert property (s_rd_gone |-> !data_oe_o)
		else $error("read data still driven after strobe end");
	AST_DATA_ON_READ: assert property (!$stable(data_o) |-> $rose(data_oe_o))
		else $error("read data changed outside a read");
	AST_CFG_WRITE: assert property (!$stable(line_control_o) || !$stable(divisor_o) |->
		!$past(wr_n_i, 6) && !$past(cs_n_i, 6))
		else $error("configuration changed without a write");
	AST_TXV_RISE: assert property ($rose(tx_valid_o) |-> !$past(wr_n_i, 4) && !$past(cs_n_i, 4))
		else $error("transmit byte appeared without a write");
	AST_ENH_MASK: assert property (!enhanced_function_o[4] |->
		modem_control_o[7:5] == 3'h0 && interrupt_enable_o[5:4] == 2'h0)
		else $error("enhanced bits active while enhanced disabled");
	AST_INT_EN_TOP: assert property (interrupt_enable_o[7:6] == 2'h0)
		else $error("unused interrupt enable bits set");
	AST_MODEM_CTL_RSVD: assert property (modem_control_o[2] == 1'b0)
		else $error("reserved modem control bit set");
endmodule // urs_regmap_props
bind urs_regmap urs_regmap_props u_urs_regmap_props (.clock_i, .rst_n_i, .cs_n_i, .rd_n_i, .wr_n_i, .data_o,
	.data_oe_o, .tx_valid_o, .line_control_o, .divisor_o, .interrupt_enable_o, .modem_control_o,
	.enhanced_function_o);

// *** bench/urs_regmap_tb.sv ***
// Self-checking bench for the register select map.
`timescale 1ns/10ps
`include "urs_defines.vh"
module urs_regmap_tb;
	logic clock_i, rst_n_i, cs_n_i, rd_n_i, wr_n_i, data_oe_o, rx_valid_i, rx_ready_o;
	logic tx_valid_o, tx_ready_i, tx_idle_i, rx_fifo_error_i;
	logic [2:0] addr_i;
	logic [3:0] line_error_i, modem_in_i, divisor_fraction_o;
	logic [5:0] int_source_i;
	logic [15:0] divisor_o;
	logic [7:0] data_i, data_o, rx_data_i, tx_data_o, line_control_o, interrupt_enable_o, fifo_control_o;
	logic [7:0] modem_control_o, enhanced_function_o, enhanced_mode_select_o, fifo_trigger_level_o;
	logic [7:0] flow_stop_char_2_o, feature_control_o, flow_resume_char_1_o, flow_resume_char_2_o, flow_stop_char_1_o;
	logic spare_output_one_o;
	logic [7:0] tx_seen[$];
	int n_fail, num_checks;
	urs_regmap u_urs_regmap (.clock_i, .rst_n_i, .cs_n_i, .addr_i, .rd_n_i, .wr_n_i, .data_i, .data_o,
		.data_oe_o, .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .tx_idle_i,
		.line_error_i, .rx_fifo_error_i, .int_source_i, .modem_in_i, .line_control_o, .divisor_o,
		.divisor_fraction_o, .interrupt_enable_o, .fifo_control_o, .modem_control_o, .spare_output_one_o,
		.feature_control_o, .enhanced_function_o, .enhanced_mode_select_o, .fifo_trigger_level_o,
		.flow_resume_char_1_o, .flow_resume_char_2_o, .flow_stop_char_1_o, .flow_stop_char_2_o);
	urs_host_model u_urs_host_model (.clock_i, .cs_n_o(cs_n_i), .addr_o(addr_i), .rd_n_o(rd_n_i),
		.wr_n_o(wr_n_i), .data_o(data_i), .rdata_i(data_o), .rdata_oe_i(data_oe_o));
	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
		if (tx_valid_o && tx_ready_i)
			tx_seen.push_back(tx_data_o);
	task automatic final_report;
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [2:0] a, input logic [7:0] d);
		u_urs_host_model.wr(a, d);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] v;
		u_urs_host_model.rd(a, v);
		chk(v & m, exp);
	endtask
	initial
	begin
		repeat (10000) @(posedge clock_i);
		n_fail++;
		final_report();
	end
	initial
	begin
		n_fail = 0;
		num_checks = 0;
		rst_n_i = 1'b0;
		rx_data_i = 8'h00;
		rx_valid_i = 1'b0;
		tx_ready_i = 1'b1;
		tx_idle_i = 1'b1;
		line_error_i = 4'h0;
		rx_fifo_error_i = 1'b0;
		int_source_i = 6'h2C;
		modem_in_i = 4'h0;
		repeat (3) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		repeat (6) @(posedge clock_i);
		#1;
		rdc(3'h3, 8'hFF, 8'h00);
		rdc(3'h4, 8'hFF, 8'h00);
		w(3'h7, 8'h5A);
		rdc(3'h7, 8'hFF, 8'h5A);
		w(3'h3, 8'h80);
		chk(line_control_o, 8'h80);
		rdc(3'h0, 8'hFF, `URS_REV_CODE);
		rdc(3'h1, 8'hFF, `URS_PART_ID);
		w(3'h0, 8'h34);
		w(3'h1, 8'h12);
		rdc(3'h0, 8'hFF, 8'h34);
		rdc(3'h1, 8'hFF, 8'h12);
		chk(divisor_o[15:8], 8'h12);
		chk(divisor_o[7:0], 8'h34);
		w(3'h3, 8'hBF);
		w(3'h2, 8'h10);
		rdc(3'h2, 8'hFF, 8'h10);
		chk(enhanced_function_o, 8'h10);
		w(3'h1, 8'h40);
		rdc(3'h1, 8'hFF, 8'h40);
		chk(feature_control_o, 8'h40);
		for (int i = 4; i < 8; i++)
			w(3'(i), 8'hC0 + 8'(i));
		for (int i = 4; i < 8; i++)
			rdc(3'(i), 8'hFF, 8'hC0 + 8'(i));
		chk(flow_stop_char_2_o, 8'hC7);
		chk(flow_resume_char_1_o, 8'hC4);
		chk(flow_resume_char_2_o, 8'hC5);
		chk(flow_stop_char_1_o, 8'hC6);
		w(3'h0, 8'h55);
		chk(fifo_trigger_level_o, 8'h55);
		w(3'h3, 8'h80);
		w(3'h2, 8'hA7);
		rdc(3'h2, 8'hFF, 8'h07);
		chk({4'h0, divisor_fraction_o}, 8'h07);
		w(3'h3, 8'h03);
		w(3'h1, 8'hFF);
		rdc(3'h1, 8'hFF, 8'h3F);
		chk(interrupt_enable_o, 8'h3F);
		w(3'h4, 8'hFF);
		rdc(3'h4, 8'hFB, 8'hFB);
		chk({7'h00, spare_output_one_o}, 8'h01);
		w(3'h2, 8'h01);
		rdc(3'h2, 8'hFF, 8'hEC);
		chk(fifo_control_o, 8'h01);
		w(3'h5, 8'h77);
		w(3'h6, 8'h66);
		w(3'h3, 8'hBF);
		w(3'h2, 8'h00);
		rdc(3'h5, 8'hFF, 8'hC5);
		rdc(3'h6, 8'hFF, 8'hC6);
		w(3'h3, 8'h03);
		rdc(3'h4, 8'hFB, 8'h1B);
		rdc(3'h1, 8'hFF, 8'h0F);
		rdc(3'h2, 8'hFF, 8'hCC);
		chk(modem_control_o, 8'h1B);
		modem_in_i = 4'h1;
		u_urs_host_model.step(4);
		rdc(3'h6, 8'hFF, 8'h11);
		rdc(3'h6, 8'hFF, 8'h10);
		for (int i = 0; i < 16; i++)
		begin
			rx_data_i = 8'h40 + 8'(i);
			rx_valid_i = 1'b1;
			u_urs_host_model.step(1);
		end
		rx_data_i = 8'hEE;
		u_urs_host_model.step(3);
		chk({7'h00, rx_ready_o}, 8'h00);
		rx_valid_i = 1'b0;
		rdc(3'h7, 8'hFF, 8'h10);
		w(3'h3, 8'hBF);
		rdc(3'h0, 8'hFF, 8'h10);
		w(3'h3, 8'h03);
		for (int i = 0; i < 16; i++)
			rdc(3'h0, 8'hFF, 8'h40 + 8'(i));
		line_error_i = 4'hA;
		rx_fifo_error_i = 1'b1;
		rdc(3'h5, 8'h9F, 8'h94);
		tx_ready_i = 1'b0;
		for (int i = 0; i < 17; i++)
			w(3'h0, 8'h80 + 8'(i));
		w(3'h7, 8'h01);
		chk(enhanced_mode_select_o, 8'h01);
		rdc(3'h7, 8'hFF, 8'h10);
		w(3'h3, 8'hBF);
		w(3'h1, 8'hC0);
		rdc(3'h0, 8'hFF, 8'h10);
		w(3'h3, 8'h03);
		rdc(3'h5, 8'h40, 8'h00);
		tx_ready_i = 1'b1;
		u_urs_host_model.step(20);
		chk(8'(tx_seen.size()), 8'h10);
		for (int i = 0; i < 16; i++)
			chk(tx_seen[i], 8'h80 + 8'(i));
		rdc(3'h5, 8'h40, 8'h40);
		rx_valid_i = 1'b1;
		u_urs_host_model.step(2);
		rx_valid_i = 1'b0;
		rdc(3'h5, 8'h01, 8'h01);
		w(3'h2, 8'h03);
		chk(fifo_control_o, 8'h01);
		rdc(3'h5, 8'h01, 8'h00);
		final_report();
	end
endmodule // urs_regmap_tb
